// ==== verilog/mbd_defines.svh ====
// offsets, field positions, reset values and timing counts for the board glue
`ifndef MBD_DEFINES_SVH
`define MBD_DEFINES_SVH
`define MBD_FMT_NIBBLE     4'hc
`define MBD_ROUTE_BIT      2
`define MBD_CTL_CNT_RST    0
`define MBD_CTL_PG_RST     1
`define MBD_CTL_IND        2
`define MBD_CTL_SEL_LO     3
`define MBD_CTL_SEL_HI     4
`define MBD_CTL_DRV_OE     5
`define MBD_CTL_HALF       6
`define MBD_CTL_SINGLE     7
`define MBD_CTL_RESET      8'h00
`define MBD_REF_CLK_HZ     12000000
`define MBD_SYS_CLK_HZ     40000000
`define MBD_MAX_STEP_HZ    3000000
`define MBD_SAMPLES_PER_STEP ((`MBD_SYS_CLK_HZ) / (`MBD_MAX_STEP_HZ))
`endif

// ==== verilog/mbd_pkg.sv ====
// types shared by the board glue files
package mbd_pkg;
  // driver mode decode
  typedef enum logic [1:0] {
    MBD_TWO_PHASE,
    MBD_HALF_STEP,
    MBD_SINGLE_PHASE,
    MBD_MODE_RESERVED
  } mbd_mode_e;
  // one host bus cycle
  typedef struct packed {
    logic       first_address_cycle;
    logic       second_address_cycle;
    logic       bus_write_cycle;
    logic       bus_read_cycle;
    logic [7:0] data;
  } mbd_bus_s;
  // outputs toward the pulse generator
  typedef struct packed {
    logic       cs_n;
    logic       wr_n;
    logic       rd_n;
    logic [1:0] addr;
    logic       reset_n;
  } mbd_pg_s;
endpackage

// ==== verilog/mbd_quad_counter.sv ====
// 16-bit quadrature position counter with byte-select output register
`timescale 1ns/100ps
`default_nettype none
`include "mbd_defines.svh"
module mbd_quad_counter import mbd_pkg::*; (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        counter_reset_n, // low holds count at zero
  input  wire logic        quad_a,          // phase a, synchronous
  input  wire logic        quad_b,          // phase b, synchronous
  input  wire logic        byte_sel,        // 0 high byte, 1 low byte
  output logic      [7:0]  count_byte,      // registered read byte
  output logic      [15:0] position         // signed position
);
  logic [1:0]  prev_reg, prev_next;     // last phase state
  logic [15:0] pos_reg, pos_next;       // position count
  logic [7:0]  byte_reg, byte_next;     // read byte latch
  logic [1:0]  cur;                     // current phase state

  // step decode on gray state change; a double jump is dropped as invalid
  always_comb begin
    cur       = {quad_a, quad_b};
    prev_next = cur;
    pos_next  = pos_reg;
    unique case ({prev_reg, cur})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: pos_next = pos_reg + 16'h0001;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: pos_next = pos_reg - 16'h0001;
      default: pos_next = pos_reg;
    endcase
    if (!counter_reset_n) pos_next = 16'h0000;
    byte_next = byte_sel ? pos_reg[7:0] : pos_reg[15:8];
  end

  // registers only
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prev_reg <= 2'h0;
      pos_reg  <= 16'h0000;
      byte_reg <= 8'h00;
    end else begin
      prev_reg <= prev_next;
      pos_reg  <= pos_next;
      byte_reg <= byte_next;
    end
  end

  assign count_byte = byte_reg;
  assign position   = pos_reg;

  a_step_up_count: assert property (@(posedge ref_clk)
    disable iff (srst)
    counter_reset_n && prev_reg == 2'b00 && {quad_a, quad_b} == 2'b01
      |=> pos_reg == $past(pos_reg) + 16'h0001)
    else $error("forward step did not increment");
  a_step_down_count: assert property (@(posedge ref_clk)
    disable iff (srst)
    counter_reset_n && prev_reg == 2'b00 && {quad_a, quad_b} == 2'b10
      |=> pos_reg == $past(pos_reg) - 16'h0001)
    else $error("reverse step did not decrement");
  a_hold_in_reset: assert property (@(posedge ref_clk)
    disable iff (srst)
    !counter_reset_n |=> pos_reg == 16'h0000)
    else $error("counter not cleared in reset");
endmodule
`default_nettype wire

// ==== verilog/mbd_bus_decode.sv ====
// board address decode, write-only control latch and target steering
`timescale 1ns/100ps
`default_nettype none
`include "mbd_defines.svh"
// Operation
// - quadrature inputs give direction, 16-bit signed count
// - count up or down per adjacent state
// - inputs sampled; step rate under quarter clock
// - count read as two bytes by select
// - 8-bit control latch, write only
// - bit0 resets counter, bit1 pulse generator
// - bit5 low enables driver, bit2 indicator
// - bits 6,7 choose driver stepping mode
// - bits 3,4 address generator, bit3 byte
// - select 00 high byte, 01 low
// - two address bytes, first low nibble 1100
// - first upper nibble matches jumper straps
// - second byte bit2 routes generator or counter
// - indicator lit when address matches board
// - sixteen boards, three targets each
// - generator register codes follow select lines
// - only reset line clears generator registers
module mbd_bus_decode import mbd_pkg::*; (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire mbd_bus_s    bus,                     // host bus cycle strobes
  input  wire logic [3:0]  address_jumper_header,   // 0 fitted, 1 open
  input  wire logic        quad_a,                  // encoder phase a
  input  wire logic        quad_b,                  // encoder phase b
  input  wire logic [7:0]  pg_data_in,              // generator read data
  output logic      [7:0]  bus_rd_data,             // byte to host
  output logic             bus_rd_oe,               // high while driving
  output mbd_pg_s          pg,                      // generator control
  output logic      [7:0]  pg_data_out,             // generator write data
  output logic             counter_reset_n,         // counter reset, low
  output logic             address_match_indicator, // lit on match, low
  output logic             status_indicator_n,      // board lamp, low on
  output logic             driver_enable_n,         // driver outputs, low
  output mbd_mode_e        driver_mode,             // stepping mode
  output logic             half_step_mode,          // half-step pin
  output logic             mode_reserved            // illegal mode written
);
  logic [7:0] latch_reg, latch_next;     // board_control_latch
  logic [7:0] addr0_reg, addr0_next;     // retained first byte
  logic       route_reg, route_next;     // 1 counter/latch, 0 generator
  logic       match_reg, match_next;     // board selected
  logic [7:0] rdat_reg, rdat_next;       // read byte to host
  logic       roe_reg, roe_next;         // read drive enable
  mbd_pg_s    pg_reg, pg_next;           // generator strobes
  logic [7:0] pgd_reg, pgd_next;         // generator write byte
  logic       ind_reg, ind_next;         // match indicator drive
  logic [7:0] cnt_byte;                  // counter byte, registered
  logic       addr0_ok;                  // first byte matches board

  // counter sees latch reset and select bit directly
  mbd_quad_counter u_mbd_quad_counter (
    .ref_clk         (ref_clk),
    .srst            (srst),
    .counter_reset_n (latch_reg[`MBD_CTL_CNT_RST]),
    .quad_a          (quad_a),
    .quad_b          (quad_b),
    .byte_sel        (latch_reg[`MBD_CTL_SEL_LO]),
    .count_byte      (cnt_byte),
    .position        ()
  );

  // jumper nibble plus 8x2 format marker
  always_comb begin
    addr0_ok = (addr0_reg[3:0] == `MBD_FMT_NIBBLE)
      && (addr0_reg[7:4] == address_jumper_header);
  end

  // address capture, latch write and read steering
  always_comb begin
    addr0_next = addr0_reg;
    route_next = route_reg;
    match_next = match_reg;
    latch_next = latch_reg;
    rdat_next  = rdat_reg;
    roe_next   = 1'b0;
    pgd_next   = pgd_reg;
    pg_next    = pg_reg;
    pg_next.cs_n = 1'b1;
    pg_next.wr_n = 1'b1;
    pg_next.rd_n = 1'b1;
    if (bus.first_address_cycle) begin
      addr0_next = bus.data;
      match_next = 1'b0;     // wait for second byte
    end else if (bus.second_address_cycle) begin
      route_next = bus.data[`MBD_ROUTE_BIT];
      match_next = addr0_ok;
    end else if (match_reg && bus.bus_write_cycle) begin
      if (route_reg) begin
        latch_next = bus.data;
      end else begin
        pg_next.cs_n = 1'b0;
        pg_next.wr_n = 1'b0;
        pgd_next     = bus.data;
      end
    end else if (match_reg && bus.bus_read_cycle) begin
      roe_next = 1'b1;
      if (route_reg) begin
        rdat_next = cnt_byte;
      end else begin
        pg_next.cs_n = 1'b0;
        pg_next.rd_n = 1'b0;
        rdat_next    = pg_data_in;
      end
    end
    // select lines drive generator address pins
    pg_next.addr    = latch_next[`MBD_CTL_SEL_HI:`MBD_CTL_SEL_LO];
    pg_next.reset_n = latch_next[`MBD_CTL_PG_RST];
    ind_next = ~(addr0_ok && match_next);
  end

  // registers only
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      latch_reg <= `MBD_CTL_RESET;
      addr0_reg <= 8'h00;
      route_reg <= 1'b0;
      match_reg <= 1'b0;
      rdat_reg  <= 8'h00;
      roe_reg   <= 1'b0;
      pg_reg    <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1,
                     addr: 2'h0, reset_n: 1'b0};
      pgd_reg   <= 8'h00;
      ind_reg   <= 1'b1;
    end else begin
      latch_reg <= latch_next;
      addr0_reg <= addr0_next;
      route_reg <= route_next;
      match_reg <= match_next;
      rdat_reg  <= rdat_next;
      roe_reg   <= roe_next;
      pg_reg    <= pg_next;
      pgd_reg   <= pgd_next;
      ind_reg   <= ind_next;
    end
  end

  // latch fields to pins; reads never return the latch itself
  assign bus_rd_data             = rdat_reg;
  assign bus_rd_oe               = roe_reg;
  assign pg                      = pg_reg;
  assign pg_data_out             = pgd_reg;
  assign counter_reset_n         = latch_reg[`MBD_CTL_CNT_RST];
  assign status_indicator_n      = latch_reg[`MBD_CTL_IND];
  assign driver_enable_n         = latch_reg[`MBD_CTL_DRV_OE];
  assign half_step_mode          = latch_reg[`MBD_CTL_HALF];
  assign driver_mode             = mbd_mode_e'(latch_reg[7:6]);
  assign mode_reserved           = &latch_reg[7:6];
  assign address_match_indicator = ind_reg;

  a_latch_write_ok: assert property (@(posedge ref_clk)
    disable iff (srst)
    match_reg && route_reg && bus.bus_write_cycle
      && !bus.first_address_cycle && !bus.second_address_cycle
      |=> latch_reg == $past(bus.data))
    else $error("latch not written");
  a_second_byte_route: assert property (@(posedge ref_clk)
    disable iff (srst)
    bus.second_address_cycle && !bus.first_address_cycle
      |=> route_reg == $past(bus.data[2]))
    else $error("route bit not taken");
  a_match_needs_jump: assert property (@(posedge ref_clk)
    disable iff (srst)
    match_reg |-> addr0_reg[7:4] == address_jumper_header)
    else $error("match without jumper equality");
  a_pg_write_sel: assert property (@(posedge ref_clk) disable iff (srst)
    !pg.wr_n |-> !pg.cs_n && pg.addr == latch_reg[4:3])
    else $error("generator write mis-addressed");
  a_read_counter_src: assert property (@(posedge ref_clk)
    disable iff (srst)
    bus_rd_oe && $past(route_reg) |-> bus_rd_data == $past(cnt_byte))
    else $error("counter byte not returned");
  a_format_nibble_chk: assert property (@(posedge ref_clk)
    disable iff (srst)
    $rose(match_reg) |-> addr0_reg[3:0] == 4'hc)
    else $error("match without format nibble");
endmodule
`default_nettype wire

// ==== bench/mbd_pg_model.sv ====
// pulse generator stand-in hanging off the glue's generator port
`timescale 1ns/100ps
`default_nettype none
module mbd_pg_model import mbd_pkg::*; (
  input  wire logic       ref_clk,
  input  wire mbd_pg_s    pg,        // strobes from the glue
  input  wire logic [7:0] wr_data,   // byte offered on writes
  output logic      [7:0] rd_data,   // status byte toward the glue
  output logic      [7:0] last_wr,   // last byte taken
  output logic      [1:0] last_addr  // register code of last write
);
  // status echoes the register code so a wrong code shows at once;
  // kept driven at all times since the glue's sample point is unknown
  assign rd_data = {6'h2a, pg.addr};
  // writes land only with select, write low and reset released
  always_ff @(posedge ref_clk) begin
    if (pg.reset_n && !pg.cs_n && !pg.wr_n) begin
      last_wr   <= wr_data;
      last_addr <= pg.addr;
    end
  end
endmodule
`default_nettype wire

// ==== bench/test_mbd_bus_decode.sv ====
// self-checking bench for the board bus glue
`timescale 1ns/100ps
`default_nettype none
module test_mbd_bus_decode import mbd_pkg::*;;
  logic        ref_clk = 0, srst = 1, qa = 0, qb = 0; // clock, phases
  mbd_bus_s    bus = '0;             // host strobes and byte
  logic [3:0]  jmp = 4'h3;           // straps abcd = 0011
  logic [7:0]  rdd, pgi, pgo, lw;    // data paths
  logic [7:0]  shadow = 8'h00;       // host copy of the latch
  logic [7:0]  got;                  // byte seen on a read
  logic        oe, oeg, cnt_n, ind_n, lamp_n, drv_n, half, resv;
  logic [1:0]  la, s = 0;            // model code, encoder phase
  mbd_pg_s     pg;                   // generator control
  mbd_mode_e   mode;                 // stepping mode
  int          err_total = 0, checked = 0, cycles = 0;

  always #12.5 ref_clk = ~ref_clk;

  mbd_bus_decode u_mbd_bus_decode (.ref_clk(ref_clk), .srst(srst),
    .bus(bus), .address_jumper_header(jmp), .quad_a(qa), .quad_b(qb),
    .pg_data_in(pgi), .bus_rd_data(rdd), .bus_rd_oe(oe), .pg(pg),
    .pg_data_out(pgo), .counter_reset_n(cnt_n),
    .address_match_indicator(ind_n), .status_indicator_n(lamp_n),
    .driver_enable_n(drv_n), .driver_mode(mode),
    .half_step_mode(half), .mode_reserved(resv));
  mbd_pg_model u_mbd_pg_model (.ref_clk(ref_clk), .pg(pg), .wr_data(pgo),
    .rd_data(pgi), .last_wr(lw), .last_addr(la));

  task automatic end_of_test;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // guard against a hung handshake
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      end_of_test;
    end
  end
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  // one strobe cycle: 0 first, 1 second, 2 write, 3 read; idle after
  task automatic cyc(int k, logic [7:0] d);
    @(negedge ref_clk);
    bus = {4'h8 >> k, d};
    @(negedge ref_clk);
    got = rdd;
    oeg = oe;
    bus = '0;
  endtask
  // latch write; extra cycle lets registered select outputs settle
  task automatic wr(logic [7:0] d);
    shadow = d;
    cyc(2, d);
    @(negedge ref_clk);
  endtask
  task automatic rd(logic [7:0] e);
    cyc(3, 8'h00);
    chk("read strobe", 1, oeg);
    chk("read byte", e, got);
  endtask
  // phase walk 00,01,11,10 counts up; 14 cycles keeps under quarter rate
  task automatic step(int n, bit up);
    repeat (n) begin
      s = up ? s + 2'd1 : s - 2'd1;
      {qa, qb} = {s[1], s[1] ^ s[0]};
      repeat (14) @(negedge ref_clk);
    end
  endtask
  task automatic t_reset;
    chk("reset outs", 16'h0005, {cnt_n, pg.reset_n, lamp_n, drv_n, half,
        resv, ind_n, oe, pg.cs_n});
    chk("reset mode", MBD_TWO_PHASE, mode);
  endtask
  task automatic t_address;
    cyc(0, 8'h4c);
    cyc(1, 8'h04);
    chk("other board", 1, ind_n);
    wr(8'hff);
    chk("write refused", 0, drv_n);
    cyc(0, 8'h3d);
    cyc(1, 8'h04);
    chk("bad format", 1, ind_n);
    cyc(0, 8'h3c);
    cyc(1, 8'h84);
    chk("own board", 0, ind_n);
  endtask
  task automatic t_latch;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {i[1:0], i[0] ? 6'h2a : 6'h15};
      wr(d);
      chk("reset lines", d[1:0], {pg.reset_n, cnt_n});
      chk("lamp and driver", {d[2], d[5]}, {lamp_n, drv_n});
      chk("select", d[4:3], pg.addr);
      chk("mode", d[7:6], mode);
      chk("half step", d[6], half);
      chk("reserved", d[7] & d[6], resv);
    end
  endtask
  task automatic t_count;
    wr(8'h03);
    step(300, 1);
    step(2, 0);
    rd(8'h01);
    wr(8'h0b);
    rd(8'h2a);
    wr(8'h0a);
    // clear reaches the count, then the byte register: one more edge
    @(negedge ref_clk);
    rd(8'h00);
    wr(8'h0b);
    step(1, 0);
    rd(8'hff);
    wr(8'h03);
    rd(8'hff);
  endtask
  task automatic t_gen;
    wr(shadow & 8'he7);
    cyc(1, 8'h00);
    chk("match kept", 0, ind_n);
    cyc(2, 8'h5d);
    chk("gen strobes", 3'b001, {pg.cs_n, pg.wr_n, pg.rd_n});
    repeat (2) @(negedge ref_clk);
    chk("command", 16'h005d, lw);
    chk("command code", 0, la);
    chk("latch untouched", 0, lamp_n);
    rd(8'ha8);
    cyc(1, 8'h04);
    wr(shadow | 8'h18);
    cyc(1, 8'h00);
    rd(8'hab);
  endtask

  initial begin
    repeat (4) @(negedge ref_clk);
    srst = 0;
    t_reset;
    t_address;
    t_latch;
    t_count;
    t_gen;
    end_of_test;
  end
endmodule
`default_nettype wire
